/* include/tict_map.svh */
// Purpose: offsets, field positions and reset values of the interval timer core
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef TICT_MAP_SVH
`define TICT_MAP_SVH
`define TICT_PORT_CNT0    2'h0
`define TICT_PORT_CNT1    2'h1
`define TICT_PORT_CNT2    2'h2
`define TICT_PORT_CTRL    2'h3
`define TICT_CW_TGT_HI    7
`define TICT_CW_TGT_LO    6
`define TICT_CW_FMT_HI    5
`define TICT_CW_FMT_LO    4
`define TICT_CW_MODE_HI   3
`define TICT_CW_MODE_LO   1
`define TICT_CW_RADIX     0
`define TICT_RB_NOCOUNT   5
`define TICT_RB_NOSTATUS  4
`define TICT_RB_SEL0      1
`define TICT_CW_RESET     6'h00
`define TICT_TGT_READBACK 2'h3
`define TICT_FMT_LATCH    2'h0
`define TICT_FMT_LOW      2'h1
`define TICT_FMT_HIGH     2'h2
`define TICT_FMT_BOTH     2'h3
`endif

/* include/tict_pkg.sv */
// Purpose: shared types of the interval timer core
// Assumes: used with tict_map.svh
// Notes:   types only
package tict_pkg;
    // host bus strobes and selects, sampled as synchronous levels
    typedef struct packed {
        logic       chipSelN;   // active low chip select
        logic       rdN;        // active low read strobe
        logic       wrN;        // active low write strobe
        logic       portSelHi;  // upper port select
        logic       portSelLo;  // lower port select
    } tict_bus_t;
    // per counter command decoded from a control port write
    typedef struct packed {
        logic       setup;      // new control word for this counter
        logic       latchCnt;   // freeze the readout latch
        logic       latchSts;   // freeze the status byte
        logic [5:0] cw;         // format, mode, radix
    } tict_cmd_t;
endpackage : tict_pkg

/* design/tict_counter.sv */
// Purpose: one counter channel: core, preset buffer, readout latch, status
// Assumes: channel clock and gate are synchronous levels on sys_clk
// Notes:   counts on the rising edge of the channel clock level
`timescale 1ns/100ps
`include "tict_map.svh"
module tict_counter (
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire tict_pkg::tict_cmd_t cmd,
    input  wire logic              wrStb,
    input  wire logic              rdStb,
    input  wire logic [7:0]        wrData,
    input  wire logic              chClk,
    input  wire logic              chGate,
    output logic [7:0]             rdData,
    output logic                   chOut
);
    import tict_pkg::*;
    logic [5:0]  cw_ff, nxt_cw;            // format, mode, radix
    logic [7:0]  presetLo_ff, nxt_presetLo; // preset_buffer_low
    logic [7:0]  presetHi_ff, nxt_presetHi; // preset_buffer_high
    logic [15:0] core_ff, nxt_core;        // counting core, host cannot reach it
    logic [15:0] latch_ff, nxt_latch;      // readout_latch
    logic        frozen_ff, nxt_frozen;    // latch holds a snapshot
    logic [7:0]  sts_ff, nxt_sts;          // latched status byte
    logic        stsHeld_ff, nxt_stsHeld;  // status pending read
    logic        pend_ff, nxt_pend;        // load pending (null count)
    logic        wrPtr_ff, nxt_wrPtr;      // next write byte is high
    logic        rdPtr_ff, nxt_rdPtr;      // next read byte is high
    logic        clkPrev_ff, nxt_clkPrev;  // channel clock edge detect
    logic        out_ff, nxt_out;          // output pin level
    logic [1:0]  fmt;
    // one decade-aware decrement, binary or four decades
    function automatic logic [15:0] dec16(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        r = v - 16'h0001;
        if (bcd) begin
            r = v;
            for (int i = 0; i < 4; i++) begin
                if (r[i*4 +: 4] != 4'h0) begin
                    r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
                    break;
                end
                r[i*4 +: 4] = 4'h9;  // borrow through this decade
            end
        end
        return r;
    endfunction : dec16
    assign fmt = cw_ff[5:4];
    // next state of the channel
    always_comb begin
        nxt_cw       = cw_ff;
        nxt_presetLo = presetLo_ff;
        nxt_presetHi = presetHi_ff;
        nxt_core     = core_ff;
        nxt_latch    = latch_ff;
        nxt_frozen   = frozen_ff;
        nxt_sts      = sts_ff;
        nxt_stsHeld  = stsHeld_ff;
        nxt_pend     = pend_ff;
        nxt_wrPtr    = wrPtr_ff;
        nxt_rdPtr    = rdPtr_ff;
        nxt_clkPrev  = chClk;
        nxt_out      = out_ff;
        rdData       = 8'h00;
        // counting: gate enables, core wraps; detailed modes lie outside this core
        if (chClk && !clkPrev_ff && chGate && !pend_ff) begin
            nxt_core = dec16(core_ff, cw_ff[0]);
            if (core_ff == 16'h0001)
                nxt_out = 1'b1;
        end
        // both buffer bytes move into the core together
        // placed before the host write so a single-byte or second-byte write in the same cycle re-arms the load (set wins)
        if (pend_ff) begin
            nxt_core = {presetHi_ff, presetLo_ff};
            nxt_pend = 1'b0;
            nxt_out  = 1'b0;
        end
        // latch tracks the core unless frozen; follows a fresh load in the same cycle
        if (!frozen_ff)
            nxt_latch = nxt_core;
        // read: status first, then latch halves one at a time
        if (rdStb) begin
            if (stsHeld_ff) begin
                rdData      = sts_ff;
                nxt_stsHeld = 1'b0;
            end else begin
                rdData = (fmt == `TICT_FMT_HIGH || (fmt == `TICT_FMT_BOTH && rdPtr_ff))
                         ? latch_ff[15:8] : latch_ff[7:0];
                if (fmt == `TICT_FMT_BOTH && !rdPtr_ff)
                    nxt_rdPtr = 1'b1;
                else begin
                    nxt_rdPtr  = 1'b0;
                    nxt_frozen = 1'b0;  // unfreeze after the full read
                end
            end
        end
        // host count write into the preset buffer
        if (wrStb) begin
            case (fmt)
                `TICT_FMT_LOW: begin
                    nxt_presetLo = wrData;
                    nxt_presetHi = 8'h00;
                    nxt_pend     = 1'b1;
                end
                `TICT_FMT_HIGH: begin
                    nxt_presetHi = wrData;
                    nxt_presetLo = 8'h00;
                    nxt_pend     = 1'b1;
                end
                `TICT_FMT_BOTH: begin
                    if (!wrPtr_ff) nxt_presetLo = wrData;
                    else begin
                        nxt_presetHi = wrData;
                        nxt_pend     = 1'b1;
                    end
                    nxt_wrPtr = !wrPtr_ff;
                end
                default: ;  // latch format, as left by reset, ignores the write
            endcase
        end
        // commands from the control port
        if (cmd.setup) begin
            nxt_cw      = cmd.cw;
            nxt_wrPtr   = 1'b0;
            nxt_rdPtr   = 1'b0;
            nxt_frozen  = 1'b0;
            nxt_stsHeld = 1'b0;
            nxt_pend    = 1'b0;
            nxt_out     = 1'b0;
        end
        if (cmd.latchCnt && !frozen_ff) begin
            nxt_latch  = core_ff;  // later commands ignored
            nxt_frozen = 1'b1;
        end
        if (cmd.latchSts && !stsHeld_ff) begin
            nxt_sts     = {out_ff, pend_ff, cw_ff};
            nxt_stsHeld = 1'b1;
        end
    end
    // register the channel state
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cw_ff       <= `TICT_CW_RESET;
            presetLo_ff <= 8'h00;
            presetHi_ff <= 8'h00;
            core_ff     <= 16'h0000;
            latch_ff    <= 16'h0000;
            frozen_ff   <= 1'b0;
            sts_ff      <= 8'h00;
            stsHeld_ff  <= 1'b0;
            pend_ff     <= 1'b0;
            wrPtr_ff    <= 1'b0;
            rdPtr_ff    <= 1'b0;
            clkPrev_ff  <= 1'b0;
            out_ff      <= 1'b0;
        end else begin
            cw_ff       <= nxt_cw;
            presetLo_ff <= nxt_presetLo;
            presetHi_ff <= nxt_presetHi;
            core_ff     <= nxt_core;
            latch_ff    <= nxt_latch;
            frozen_ff   <= nxt_frozen;
            sts_ff      <= nxt_sts;
            stsHeld_ff  <= nxt_stsHeld;
            pend_ff     <= nxt_pend;
            wrPtr_ff    <= nxt_wrPtr;
            rdPtr_ff    <= nxt_rdPtr;
            clkPrev_ff  <= nxt_clkPrev;
            out_ff      <= nxt_out;
        end
    end
    assign chOut = out_ff;
    // a held latch stays fixed until read or reprogrammed
    latch_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
        frozen_ff && !rdStb && !cmd.setup |=> latch_ff == $past(latch_ff))
        else $error("frozen latch changed");
    // low byte format clears the high byte
    low_only_a: assert property (@(posedge sys_clk) disable iff (srst)
        wrStb && fmt == `TICT_FMT_LOW && !cmd.setup |=> presetHi_ff == 8'h00)
        else $error("high preset byte not cleared");
endmodule : tict_counter

/* design/tict_timer_core.sv */
// Purpose: three channel interval timer, host byte bus and control port
// Assumes: bus strobes are synchronous levels; one action per strobe fall
// Notes:   data bus is split into input, output and output enable
`timescale 1ns/100ps
`include "tict_map.svh"
module tict_timer_core #(
    parameter int NUM_CH = 3  // channel count
) (
    input  wire logic                  sys_clk,
    input  wire logic                  srst,
    input  wire tict_pkg::tict_bus_t   hostBus,
    input  wire logic [7:0]            dataIn,
    output logic [7:0]                 dataOut,
    output logic                       dataOe,
    input  wire logic [NUM_CH-1:0]     chClk,
    input  wire logic [NUM_CH-1:0]     chGate,
    output logic [NUM_CH-1:0]          chOut
);
    import tict_pkg::*;
    logic              rdPrev_ff, nxt_rdPrev;  // read strobe history
    logic              wrPrev_ff, nxt_wrPrev;  // write strobe history
    logic [7:0]        dOut_ff, nxt_dOut;      // registered bus data
    logic              dOe_ff, nxt_dOe;        // registered bus enable
    logic [NUM_CH-1:0] out_ff;                 // registered channel outputs
    logic [1:0]        port;
    logic              rdLow, wrLow, rdStart, wrStart;
    logic [NUM_CH-1:0] wrStb, rdStb;
    tict_cmd_t         cmd [NUM_CH];
    logic [7:0]        chData [NUM_CH];
    logic [7:0]        cwByte;
    logic [2:0]        modeNorm;
    assign port    = {hostBus.portSelHi, hostBus.portSelLo};
    assign rdLow   = !hostBus.chipSelN && !hostBus.rdN;
    assign wrLow   = !hostBus.chipSelN && !hostBus.wrN;
    assign rdStart = rdLow && !rdPrev_ff;
    assign wrStart = wrLow && !wrPrev_ff;
    assign cwByte  = dataIn;
    // mode 2 and 3 ignore the top mode bit; store it cleared
    always_comb begin
        modeNorm = cwByte[`TICT_CW_MODE_HI:`TICT_CW_MODE_LO];
        if (modeNorm[1])
            modeNorm[2] = 1'b0;
    end
    // decode strobes and control port commands per channel
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            wrStb[i] = wrStart && port == 2'(i);
            rdStb[i] = rdStart && port == 2'(i);
            cmd[i]   = '0;
            cmd[i].cw = {cwByte[`TICT_CW_FMT_HI:`TICT_CW_FMT_LO], modeNorm, cwByte[`TICT_CW_RADIX]};
            if (wrStart && port == `TICT_PORT_CTRL) begin
                if (cwByte[`TICT_CW_TGT_HI:`TICT_CW_TGT_LO] == `TICT_TGT_READBACK) begin
                    cmd[i].latchCnt = cwByte[`TICT_RB_SEL0 + i] && !cwByte[`TICT_RB_NOCOUNT];
                    cmd[i].latchSts = cwByte[`TICT_RB_SEL0 + i] && !cwByte[`TICT_RB_NOSTATUS];
                end else if (cwByte[`TICT_CW_TGT_HI:`TICT_CW_TGT_LO] == 2'(i)) begin
                    if (cwByte[`TICT_CW_FMT_HI:`TICT_CW_FMT_LO] == `TICT_FMT_LATCH)
                        cmd[i].latchCnt = 1'b1;
                    else
                        cmd[i].setup = 1'b1;
                end
            end
        end
    end
    // channels, identical and independent
    for (genvar g = 0; g < NUM_CH; g++) begin : gCh
        tict_counter uCnt (
            .sys_clk (sys_clk),
            .srst    (srst),
            .cmd     (cmd[g]),
            .wrStb   (wrStb[g]),
            .rdStb   (rdStb[g]),
            .wrData  (dataIn),
            .chClk   (chClk[g]),
            .chGate  (chGate[g]),
            .rdData  (chData[g]),
            .chOut   (out_ff[g])
        );
    end
    // read mux and bus drive; control port reads give nothing
    always_comb begin
        nxt_rdPrev = rdLow;
        nxt_wrPrev = wrLow;
        nxt_dOut   = dOut_ff;
        nxt_dOe    = rdLow && port != `TICT_PORT_CTRL;
        if (rdStart) begin
            nxt_dOut = 8'h00;
            for (int i = 0; i < NUM_CH; i++)
                if (port == 2'(i))
                    nxt_dOut = chData[i];
        end
    end
    // register the bus side
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdPrev_ff <= 1'b0;
            wrPrev_ff <= 1'b0;
            dOut_ff   <= 8'h00;
            dOe_ff    <= 1'b0;
        end else begin
            rdPrev_ff <= nxt_rdPrev;
            wrPrev_ff <= nxt_wrPrev;
            dOut_ff   <= nxt_dOut;
            dOe_ff    <= nxt_dOe;
        end
    end
    assign dataOut = dOut_ff;
    assign dataOe  = dOe_ff;
    assign chOut   = out_ff;
    // no bus drive without chip select
    cs_gate_a: assert property (@(posedge sys_clk) disable iff (srst)
        hostBus.chipSelN |=> !dataOe)
        else $error("bus driven while deselected");
    // control port never drives the bus
    ctrl_wo_a: assert property (@(posedge sys_clk) disable iff (srst)
        port == `TICT_PORT_CTRL |=> !dataOe)
        else $error("control port read drove bus");
    // read drives within one cycle
    rd_drive_a: assert property (@(posedge sys_clk) disable iff (srst)
        rdLow && port != `TICT_PORT_CTRL |=> dataOe)
        else $error("read not driven");
    // no write strobe to counter 0 when not selected
    wr_decode_a: assert property (@(posedge sys_clk) disable iff (srst)
        wrStb[0] |-> port == `TICT_PORT_CNT0 && !hostBus.chipSelN)
        else $error("counter 0 write misdecoded");
    // mode bit two cleared for modes 2 and 3
    mode_norm_a: assert property (@(posedge sys_clk) disable iff (srst)
        wrStart && port == `TICT_PORT_CTRL && cwByte[2] |-> cmd[0].cw[3] == 1'b0)
        else $error("mode top bit kept");
    // read-back of counter 0 count latches it
    rb_latch_a: assert property (@(posedge sys_clk) disable iff (srst)
        wrStart && port == `TICT_PORT_CTRL && cwByte[7:6] == 2'h3 && cwByte[1] && !cwByte[5]
        |-> cmd[0].latchCnt)
        else $error("read-back latch missed");
endmodule : tict_timer_core

/* tb/tict_host_model.sv */
// Purpose: host processor model driving the timer byte bus
// Assumes: the bench calls access from one process only
// Notes:   write data is not kept once a write ends
`timescale 1ns/100ps
module tict_host_model (
    input  wire logic            sys_clk,
    output tict_pkg::tict_bus_t  hostBus,
    output logic [7:0]           dataIn,
    input  wire logic [7:0]      dataOut,
    input  wire logic            dataOe
);
    import tict_pkg::*;

    // idle bus: chip deselected, both strobes high
    initial begin
        hostBus = '{chipSelN: 1'b1, rdN: 1'b1, wrN: 1'b1, portSelHi: 1'b0, portSelLo: 1'b0};
        dataIn  = 8'h00;
    end

    // one strobe per call; held across the taking edge, released on the next fall
    // the strobe is high for at least one rising edge between two calls
    task automatic access(input logic [1:0] port, input logic isWr, input logic csN,
                          input logic [7:0] wData, output logic [7:0] rData, output logic oe);
        @(negedge sys_clk);
        hostBus.chipSelN  = csN;
        hostBus.rdN       = isWr;
        hostBus.wrN       = ~isWr;
        hostBus.portSelHi = port[1];
        hostBus.portSelLo = port[0];
        dataIn            = isWr ? wData : ~dataIn;      // reads: lines not held
        @(negedge sys_clk);
        rData             = dataOut;
        oe                = dataOe;
        hostBus.chipSelN  = 1'b1;
        hostBus.rdN       = 1'b1;
        hostBus.wrN       = 1'b1;
        dataIn            = ~dataIn;                     // released: never the last value
    endtask : access
endmodule : tict_host_model

/* tb/tb_top.sv */
// Purpose: self-checking bench of the interval timer core
// Assumes: counters are programmed before use, control word first
// Notes:   gates stay low except while ticking, so counts are stable
`timescale 1ns/100ps
module tb_top;
    import tict_pkg::*;

    logic                sys_clk = 1'b0;  // 40 MHz system clock
    logic                srst;            // sync reset, active high
    tict_bus_t           hostBus;         // strobes and selects from host
    logic [7:0]          dataIn;          // write data from host
    logic [7:0]          dataOut;         // read data to host
    logic                dataOe;          // read data enable
    logic [2:0]          chClk;           // channel clock levels
    logic [2:0]          chGate;          // channel gate levels
    logic [2:0]          chOut;           // channel outputs
    logic [7:0]          rdv;             // scratch read value
    logic                rdOe;            // scratch enable value
    int                  badCount = 0;    // mismatches
    int                  nTests   = 0;    // comparisons
    // control words 5:0, low byte format, all eight mode codes, both radices
    logic [5:0]          cwTab [8] = '{6'h10, 6'h13, 6'h14, 6'h17, 6'h18, 6'h1B, 6'h1C, 6'h1F};
    // status words expected back: modes 2 and 3 keep their top mode bit cleared
    logic [5:0]          cwExp [8] = '{6'h10, 6'h13, 6'h14, 6'h17, 6'h18, 6'h1B, 6'h14, 6'h17};

    // free running clock
    always #12.5 sys_clk = ~sys_clk;

    tict_timer_core #(.NUM_CH(3)) dut (
        .sys_clk (sys_clk),
        .srst    (srst),
        .hostBus (hostBus),
        .dataIn  (dataIn),
        .dataOut (dataOut),
        .dataOe  (dataOe),
        .chClk   (chClk),
        .chGate  (chGate),
        .chOut   (chOut)
    );

    tict_host_model host (
        .sys_clk (sys_clk),
        .hostBus (hostBus),
        .dataIn  (dataIn),
        .dataOut (dataOut),
        .dataOe  (dataOe)
    );

    // single comparison point
    task automatic check(input logic [7:0] seen, input logic [7:0] expv);
        nTests++;
        if (seen !== expv) begin
            badCount++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask : check

    // selected byte write
    task automatic wr(input logic [1:0] port, input logic [7:0] d);
        logic [7:0] r;
        logic       oe;
        host.access(port, 1'b1, 1'b0, d, r, oe);
    endtask : wr

    // selected read, enable and byte both checked
    task automatic rdExp(input logic [1:0] port, input logic [7:0] expv);
        logic [7:0] r;
        logic       oe;
        host.access(port, 1'b0, 1'b0, 8'h00, r, oe);
        check({7'h00, oe}, 8'h01);
        check(r, expv);
    endtask : rdExp

    // n rising channel clocks with the gate open, then gate shut again
    task automatic tick(input int ch, input int n);
        @(negedge sys_clk) chGate[ch] = 1'b1;
        repeat (n) begin
            @(negedge sys_clk) chClk[ch] = 1'b1;
            @(negedge sys_clk) chClk[ch] = 1'b0;
        end
        @(negedge sys_clk) chGate[ch] = 1'b0;
    endtask : tick

    // counts, verdict, end of run
    task automatic closeOut();
        $display("comparisons %0d, mismatches %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : closeOut

    // hang guard, far beyond the under two hundred cycles the run needs
    initial begin
        #50000;
        badCount++;
        closeOut();
    end

    // main sequence
    initial begin
        srst   = 1'b1;
        chClk  = 3'h0;
        chGate = 3'h0;
        repeat (12) @(negedge sys_clk);
        check({5'h00, chOut}, 8'h00);
        check({7'h00, dataOe}, 8'h00);
        srst = 1'b0;
        // counter 0, two byte count; a half written count is dropped by reprogramming
        wr(2'h3, 8'h30);
        wr(2'h0, 8'h99);
        wr(2'h3, 8'h30);
        wr(2'h0, 8'h34);
        wr(2'h0, 8'h12);
        rdExp(2'h0, 8'h34);
        rdExp(2'h0, 8'h12);
        // deselected strobes and the write-only port
        host.access(2'h0, 1'b1, 1'b1, 8'h77, rdv, rdOe);
        host.access(2'h0, 1'b0, 1'b1, 8'h00, rdv, rdOe);
        check({7'h00, rdOe}, 8'h00);
        host.access(2'h3, 1'b0, 1'b0, 8'h00, rdv, rdOe);
        check({7'h00, rdOe}, 8'h00);
        rdExp(2'h0, 8'h34);
        rdExp(2'h0, 8'h12);
        // freeze, count on, second freeze ignored, then tracking again
        wr(2'h3, 8'h00);
        tick(0, 2);
        wr(2'h3, 8'h00);
        rdExp(2'h0, 8'h34);
        rdExp(2'h0, 8'h12);
        rdExp(2'h0, 8'h32);
        rdExp(2'h0, 8'h12);
        // read-back count latch of counter 0 alone, then tracking again
        wr(2'h3, 8'hD2);
        tick(0, 1);
        rdExp(2'h0, 8'h32);
        rdExp(2'h0, 8'h12);
        rdExp(2'h0, 8'h31);
        rdExp(2'h0, 8'h12);
        // counter 2: stale low byte must not survive a high byte only load
        wr(2'h3, 8'h90);
        wr(2'h2, 8'hAB);
        wr(2'h3, 8'hA0);
        wr(2'h2, 8'h01);
        tick(2, 1);
        rdExp(2'h2, 8'h00);
        // only counter 2 output rises once its count runs through
        wr(2'h3, 8'h90);
        wr(2'h2, 8'h02);
        tick(2, 3);
        check({5'h00, chOut}, 8'h04);
        // counter 1 status byte for every mode code and both radices
        foreach (cwTab[i]) begin
            wr(2'h3, {2'h1, cwTab[i]});
            wr(2'h1, 8'h45);
            wr(2'h3, 8'hE4);
            rdExp(2'h1, {2'h0, cwExp[i]});
        end
        // count only read-back on counter 1
        wr(2'h3, 8'hD4);
        rdExp(2'h1, 8'h45);
        // decimal radix: 10 counts down to 09, not 0F
        wr(2'h1, 8'h10);
        tick(1, 1);
        rdExp(2'h1, 8'h09);
        closeOut();
    end
endmodule : tb_top
